// File: pmid_host.sv
`timescale 1ns/1ps

// ------------------------------------------
// Host side of the block command port
// ------------------------------------------
module pmid_host (
   input wire logic ref_clk,
   output logic txn_start,
   output logic [7:0] txn_cmd,
   output logic txn_write,
   output logic txn_stop,
   output logic wr_byte_valid,
   output logic [7:0] wr_byte,
   output logic rd_byte_req
);
   initial begin
      txn_start = 1'b0;
      txn_cmd = 8'h00;
      txn_write = 1'b0;
      txn_stop = 1'b0;
      wr_byte_valid = 1'b0;
      wr_byte = 8'h00;
      rd_byte_req = 1'b0;
   end

   task automatic open_txn(input logic [7:0] cmd, input logic wr);
      @(negedge ref_clk);
      txn_start <= 1'b1;
      txn_cmd <= cmd;
      txn_write <= wr;
      @(negedge ref_clk);
      txn_start <= 1'b0;
      txn_cmd <= ~cmd;
   endtask : open_txn

   // Released byte lane shows the inverse so a stale value cannot pass
   task automatic close_txn();
      wr_byte_valid <= 1'b0;
      wr_byte <= ~wr_byte;
      rd_byte_req <= 1'b0;
      txn_stop <= 1'b1;
      @(negedge ref_clk);
      txn_stop <= 1'b0;
      @(negedge ref_clk);
   endtask : close_txn

   task automatic write_block(input logic [7:0] cmd, input logic [7:0] cnt, input int n,
                              input logic [31:0] d);
      open_txn(cmd, 1'b1);
      for (int i = 0; i < n; i++) begin
         wr_byte_valid <= 1'b1;
         wr_byte <= (i == 0) ? cnt : 8'(d >> (8 * (i - 1)));
         @(negedge ref_clk);
      end
      close_txn();
   endtask : write_block

   task automatic read_block(input logic [7:0] cmd, input int n);
      open_txn(cmd, 1'b0);
      for (int i = 0; i < n; i++) begin
         rd_byte_req <= 1'b1;
         @(negedge ref_clk);
      end
      close_txn();
   endtask : read_block
endmodule : pmid_host

// File: pmid_pkg.sv
package pmid_pkg;

   typedef enum logic [1:0] {
      PMID_IDLE,
      PMID_WRITE,
      PMID_READ
   } pmid_phase_type;

   typedef struct packed {
      pmid_phase_type phase;
      logic [7:0] cmd;
      logic [3:0] idx;
      logic [7:0] count;
      logic [23:0] shadow;
      logic [23:0] revision;
      logic [23:0] serial;
      logic [7:0] rd_data;
      logic rd_valid;
      logic nack;
      logic done;
      logic [7:0] checksum;
   } pmid_state_type;

endpackage : pmid_pkg

// File: pmid_store.sv
`timescale 1ns/1ps
`include "pmid_store_params.svh"

module pmid_store
   import pmid_pkg::*;
#(
   // Arbitrary neutral value, not a real part code
   parameter logic [47:0] PART_TYPE_CODE = 48'h0123_4567_89AB
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic clk_en,
   input wire logic [23:0] nvm_revision,
   input wire logic [23:0] nvm_serial,
   input wire logic txn_start,
   input wire logic [7:0] txn_cmd,
   input wire logic txn_write,
   input wire logic txn_stop,
   input wire logic wr_byte_valid,
   input wire logic [7:0] wr_byte,
   input wire logic rd_byte_req,
   output logic [7:0] rd_byte,
   output logic rd_byte_valid,
   output logic txn_nack,
   output logic write_done,
   output logic [23:0] maker_revision_store,
   output logic [23:0] maker_serial_number,
   output logic [7:0] stored_config_checksum
);

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   function automatic logic [7:0] pick_byte(input logic [47:0] d, input logic [3:0] k);
      logic [47:0] s;
      s = d >> {k, 3'b000};
      return s[7:0];
   endfunction : pick_byte

   // Plain byte sum; stands in for the real checksum engine elsewhere
   function automatic logic [7:0] byte_sum(input logic [23:0] rev, input logic [23:0] ser);
      logic [7:0] acc;
      acc = 8'h00;
      for (int i = 0; i < 3; i++) begin
         acc = acc + rev[i*8 +: 8] + ser[i*8 +: 8];
      end
      return acc;
   endfunction : byte_sum

   function automatic logic [7:0] reg_len(input logic [7:0] c);
      if (c == `PMID_CMD_PART) begin
         return `PMID_LEN_PART;
      end else if (c == `PMID_CMD_SERIAL) begin
         return `PMID_LEN_SERIAL;
      end
      return `PMID_LEN_REVISION;
   endfunction : reg_len

   pmid_state_type st_reg;
   pmid_state_type st_next;
   logic known_cmd;
   logic commit_ok;
   logic [47:0] read_src;

   assign known_cmd = (txn_cmd == `PMID_CMD_SERIAL) || (txn_cmd == `PMID_CMD_PART)
      || (txn_cmd == `PMID_CMD_REVISION);
   assign commit_ok = (st_reg.count == reg_len(st_reg.cmd)) && (st_reg.idx == `PMID_WR_LAST_IDX);

   always_comb begin
      unique case (st_reg.cmd)
         `PMID_CMD_PART: read_src = PART_TYPE_CODE;
         `PMID_CMD_SERIAL: read_src = {24'h000000, st_reg.serial};
         default: read_src = {24'h000000, st_reg.revision};
      endcase
   end

   // ---------------------------------------------
   // Transaction engine
   // ---------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.rd_valid = 1'b0;
      st_next.nack = 1'b0;
      st_next.done = 1'b0;
      unique case (st_reg.phase)
         PMID_IDLE: begin
            if (txn_start) begin
               st_next.cmd = txn_cmd;
               st_next.idx = 4'h0;
               st_next.count = 8'h00;
               st_next.shadow = 24'h000000;
               if (!known_cmd || (txn_write && txn_cmd == `PMID_CMD_PART)) begin
                  st_next.nack = 1'b1;
               end else if (txn_write) begin
                  st_next.phase = PMID_WRITE;
               end else begin
                  st_next.phase = PMID_READ;
               end
            end
         end
         PMID_WRITE: begin
            if (txn_stop) begin
               st_next.phase = PMID_IDLE;
               // Short or long blocks are dropped whole so no partial value is kept
               if (commit_ok) begin
                  st_next.done = 1'b1;
                  if (st_reg.cmd == `PMID_CMD_SERIAL) begin
                     st_next.serial = st_reg.shadow;
                  end else begin
                     st_next.revision = st_reg.shadow;
                  end
               end else begin
                  st_next.nack = 1'b1;
               end
            end else if (wr_byte_valid) begin
               unique case (st_reg.idx)
                  4'h0: st_next.count = wr_byte;
                  4'h1: st_next.shadow[7:0] = wr_byte;
                  4'h2: st_next.shadow[15:8] = wr_byte;
                  4'h3: st_next.shadow[23:16] = wr_byte;
                  default: st_next.shadow = st_reg.shadow;
               endcase
               if (st_reg.idx != `PMID_IDX_MAX) begin
                  st_next.idx = st_reg.idx + 4'h1;
               end
            end
         end
         PMID_READ: begin
            if (txn_stop) begin
               st_next.phase = PMID_IDLE;
            end else if (rd_byte_req) begin
               st_next.rd_valid = 1'b1;
               if (st_reg.idx == 4'h0) begin
                  st_next.rd_data = reg_len(st_reg.cmd);
               end else if ({4'h0, st_reg.idx} <= reg_len(st_reg.cmd)) begin
                  st_next.rd_data = pick_byte(read_src, st_reg.idx - 4'h1);
               end else begin
                  st_next.rd_data = `PMID_READ_FILL;
               end
               if (st_reg.idx != `PMID_IDX_MAX) begin
                  st_next.idx = st_reg.idx + 4'h1;
               end
            end
         end
         default: st_next.phase = PMID_IDLE;
      endcase
      st_next.checksum = byte_sum(st_next.revision, st_next.serial);
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_reg <= '0;
         st_reg.revision <= nvm_revision;
         st_reg.serial <= nvm_serial;
         st_reg.checksum <= byte_sum(nvm_revision, nvm_serial);
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end

   assign rd_byte = st_reg.rd_data;
   assign rd_byte_valid = st_reg.rd_valid;
   assign txn_nack = st_reg.nack;
   assign write_done = st_reg.done;
   assign maker_revision_store = st_reg.revision;
   assign maker_serial_number = st_reg.serial;
   assign stored_config_checksum = st_reg.checksum;

   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   sequence s_read_step;
      clk_en && st_reg.phase == PMID_READ && !txn_stop && rd_byte_req;
   endsequence

   sequence s_serial_stop;
      clk_en && st_reg.phase == PMID_WRITE && txn_stop && st_reg.cmd == `PMID_CMD_SERIAL;
   endsequence

   a_reset_reload: assert property (@(posedge ref_clk)
      $fell(srst) |-> maker_revision_store == $past(nvm_revision)
         && maker_serial_number == $past(nvm_serial))
      else $error("stores not reloaded from nvm at reset");

   a_serial_commit: assert property (@(posedge ref_clk) disable iff (srst)
      s_serial_stop ##0 commit_ok |=> write_done && maker_serial_number == $past(st_reg.shadow))
      else $error("serial block write not committed");

   a_bad_count_drop: assert property (@(posedge ref_clk) disable iff (srst)
      s_serial_stop ##0 !commit_ok |=> txn_nack && $stable(maker_serial_number))
      else $error("malformed serial write not dropped");

   a_serial_held: assert property (@(posedge ref_clk) disable iff (srst)
      !(clk_en && st_reg.phase == PMID_WRITE && txn_stop && st_reg.cmd == `PMID_CMD_SERIAL
         && commit_ok) |=> $stable(maker_serial_number))
      else $error("serial changed without commit");

   a_count_first: assert property (@(posedge ref_clk) disable iff (srst)
      s_read_step ##0 st_reg.idx == 4'h0 |=> rd_byte_valid && rd_byte == reg_len(st_reg.cmd))
      else $error("block read did not start with byte count");

   a_serial_bytes: assert property (@(posedge ref_clk) disable iff (srst)
      s_read_step ##0 (st_reg.cmd == `PMID_CMD_SERIAL && st_reg.idx == 4'h4)
         |=> rd_byte == `PMID_READ_FILL)
      else $error("serial read longer than three bytes");

   a_part_bytes: assert property (@(posedge ref_clk) disable iff (srst)
      s_read_step ##0 (st_reg.cmd == `PMID_CMD_PART && st_reg.idx >= 4'h1 && st_reg.idx <= 4'h6)
         |=> rd_byte == pick_byte(PART_TYPE_CODE, $past(st_reg.idx) - 4'h1))
      else $error("part-type byte wrong");

   a_part_no_write: assert property (@(posedge ref_clk) disable iff (srst)
      clk_en && st_reg.phase == PMID_IDLE && txn_start && txn_write && txn_cmd == `PMID_CMD_PART
         |=> txn_nack && st_reg.phase == PMID_IDLE)
      else $error("write to part-type code not refused");

   a_checksum_track: assert property (@(posedge ref_clk) disable iff (srst)
      $changed(maker_serial_number) |-> stored_config_checksum
         == byte_sum(maker_revision_store, maker_serial_number))
      else $error("checksum does not follow serial");

endmodule : pmid_store

// File: pmid_store_params.svh
`ifndef PMID_STORE_PARAMS_SVH
`define PMID_STORE_PARAMS_SVH

// ---------------------------------------------
// Command codes
// ---------------------------------------------
`define PMID_CMD_REVISION 8'h9B
`define PMID_CMD_SERIAL 8'h9E
`define PMID_CMD_PART 8'hAD

// ---------------------------------------------
// Register lengths in bytes and field layout
// ---------------------------------------------
`define PMID_LEN_REVISION 8'h03
`define PMID_LEN_SERIAL 8'h03
`define PMID_LEN_PART 8'h06
`define PMID_STORE_MSB 23
`define PMID_PART_MSB 47
`define PMID_WR_LAST_IDX 4'h4
`define PMID_IDX_MAX 4'hF

// ---------------------------------------------
// Read filler past the end of a register
// ---------------------------------------------
`define PMID_READ_FILL 8'hFF

`endif

// File: pmid_store_tb.sv
`timescale 1ns/1ps
`include "pmid_store_params.svh"

module pmid_store_tb;
   import pmid_pkg::*;
   localparam logic [47:0] PART = 48'h5A3C_C3A5_0F96;
   logic ref_clk, srst, clk_en, txn_start, txn_write, txn_stop, wr_byte_valid, rd_byte_req;
   logic [7:0] txn_cmd, wr_byte, rd_byte, stored_config_checksum;
   logic rd_byte_valid, txn_nack, write_done;
   logic [23:0] nvm_revision, nvm_serial, maker_revision_store, maker_serial_number, rev, ser;
   logic [8:0] exp_q[$];
   int errors, cmp_count;

   pmid_store #(.PART_TYPE_CODE(PART)) dut (.ref_clk, .srst, .clk_en, .nvm_revision,
      .nvm_serial, .txn_start, .txn_cmd, .txn_write, .txn_stop, .wr_byte_valid, .wr_byte,
      .rd_byte_req, .rd_byte, .rd_byte_valid, .txn_nack, .write_done, .maker_revision_store,
      .maker_serial_number, .stored_config_checksum);
   pmid_host host (.ref_clk, .txn_start, .txn_cmd, .txn_write, .txn_stop, .wr_byte_valid,
      .wr_byte, .rd_byte_req);

   // ------------------------------------------
   // Checking
   // ------------------------------------------
   task automatic cmp_byte(input logic [8:0] got);
      logic [8:0] e;
      cmp_count++;
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1AA;
      if (got !== e) begin
         errors++;
         $display("mismatch at %0t: result %h expected %h", $time, got, e);
      end
   endtask : cmp_byte

   task automatic cmp_val(input logic [23:0] got, input logic [23:0] e);
      cmp_count++;
      if (got !== e) begin
         errors++;
         $display("mismatch at %0t: value %h expected %h", $time, got, e);
      end
   endtask : cmp_val

   // Bit 8 set marks a write status, 01 commit and 00 refusal
   always @(posedge ref_clk) begin
      #1;
      if (rd_byte_valid === 1'b1) cmp_byte({1'b0, rd_byte});
      if (write_done === 1'b1 || txn_nack === 1'b1) cmp_byte({8'h80, write_done});
   end

   function automatic logic [7:0] csum(input logic [23:0] r, input logic [23:0] s);
      return r[7:0] + r[15:8] + r[23:16] + s[7:0] + s[15:8] + s[23:16];
   endfunction : csum

   task automatic regs();
      cmp_val(maker_revision_store, rev);
      cmp_val(maker_serial_number, ser);
      cmp_val({16'h0000, stored_config_checksum}, {16'h0000, csum(rev, ser)});
   endtask : regs

   task automatic wr(input logic [7:0] cmd, input logic [7:0] cnt, input int n,
                     input logic [31:0] d, input logic ok);
      exp_q.push_back({8'h80, ok});
      host.write_block(cmd, cnt, n, d);
      regs();
   endtask : wr

   // One byte past the length checks the filler
   task automatic rd(input logic [7:0] cmd, input logic [7:0] len, input logic [47:0] d);
      exp_q.push_back({1'b0, len});
      for (int i = 0; i < len; i++) exp_q.push_back({1'b0, 8'(d >> (8 * i))});
      exp_q.push_back({1'b0, `PMID_READ_FILL});
      host.read_block(cmd, len + 2);
   endtask : rd

   task automatic give_verdict();
      if (errors == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : give_verdict

   // ------------------------------------------
   // Stimulus
   // ------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   initial begin
      #200us;
      errors++;
      $display("mismatch at %0t: run did not finish", $time);
      give_verdict();
   end

   initial begin
      errors = 0;
      cmp_count = 0;
      srst = 1'b1;
      clk_en = 1'b1;
      void'($urandom(77622));
      nvm_revision = 24'($urandom);
      nvm_serial = 24'($urandom);
      rev = nvm_revision;
      ser = nvm_serial;
      repeat (20) @(negedge ref_clk);
      srst <= 1'b0;
      @(negedge ref_clk);
      nvm_revision <= ~rev;
      nvm_serial <= ~ser;
      regs();
      // Serial written once, as at manufacture; the revision store takes rewrites
      ser = 24'($urandom);
      wr(`PMID_CMD_SERIAL, `PMID_LEN_SERIAL, 4, {8'h00, ser}, 1'b1);
      for (int i = 0; i < 3; i++) begin
         rd(`PMID_CMD_SERIAL, `PMID_LEN_SERIAL, {24'h000000, ser});
         rev = 24'($urandom);
         wr(`PMID_CMD_REVISION, `PMID_LEN_REVISION, 4, {8'h00, rev}, 1'b1);
         rd(`PMID_CMD_REVISION, `PMID_LEN_REVISION, {24'h000000, rev});
      end
      // Frozen clock enable: the whole write is lost and the store keeps its value
      clk_en <= 1'b0;
      host.write_block(`PMID_CMD_REVISION, `PMID_LEN_REVISION, 4, {8'h00, ~rev});
      clk_en <= 1'b1;
      regs();
      // Unknown command code is refused
      exp_q.push_back({8'h80, 1'b0});
      host.read_block(8'h5A, 1);
      wr(`PMID_CMD_SERIAL, 8'h02, 3, $urandom, 1'b0);
      wr(`PMID_CMD_SERIAL, 8'h03, 5, $urandom, 1'b0);
      wr(`PMID_CMD_PART, `PMID_LEN_PART, 0, 32'h0000_0000, 1'b0);
      rd(`PMID_CMD_PART, `PMID_LEN_PART, PART);
      // Second reset in mid-run reloads both stores from new nvm values
      rev = 24'($urandom);
      ser = 24'($urandom);
      nvm_revision <= rev;
      nvm_serial <= ser;
      srst <= 1'b1;
      repeat (3) @(negedge ref_clk);
      srst <= 1'b0;
      @(negedge ref_clk);
      regs();
      rd(`PMID_CMD_SERIAL, `PMID_LEN_SERIAL, {24'h000000, ser});
      repeat (4) @(negedge ref_clk);
      cmp_val(24'(exp_q.size()), 24'h000000);
      give_verdict();
   end
endmodule : pmid_store_tb
